// file: design/scsc_pkg.sv
/*
  Package for the system clock select control block: register offsets,
  field positions, reset values, unlock keys and timing counts.
  Assumes a 32-bit classic Wishbone register bus and a 50 MHz clock.
*/
package scsc_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [3:0] SCSC_OFF_CTRL   = 4'h0; // oscillator_control_reg
  localparam logic [3:0] SCSC_OFF_UNLOCK = 4'h4; // unlock key port
  localparam logic [3:0] SCSC_OFF_STATUS = 4'h8; // interrupt status, write one clears
  localparam logic [3:0] SCSC_OFF_MASK   = 4'hC; // interrupt mask

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int SCSC_CTL_SEL_LSB = 0;  // [1:0] clock source select
  localparam int SCSC_CTL_RC_EN   = 2;  // RC oscillator enable
  localparam int SCSC_CTL_RC_LOW  = 3;  // RC low frequency setting
  localparam int SCSC_CTL_FD_EN   = 4;  // failure detection enable
  localparam int SCSC_CTL_FAILED  = 5;  // read only: running on fallback
  localparam int SCSC_CTL_LOCKED  = 6;  // read only: register locked
  localparam int SCSC_CTL_ACT_LSB = 8;  // [9:8] read only: active source

  localparam logic [1:0] SCSC_SRC_RC  = 2'h0;
  localparam logic [1:0] SCSC_SRC_EXT = 2'h1;
  localparam logic [1:0] SCSC_SRC_WDO = 2'h2;

  localparam logic [4:0] SCSC_CTL_RESET = 5'h04; // RC high, enabled, no detection

  // ****************************************
  // Unlock keys, written in this order
  // ****************************************
  localparam logic [7:0] SCSC_KEY1 = 8'hE7;
  localparam logic [7:0] SCSC_KEY2 = 8'h18;

  // ****************************************
  // Status bits
  // ****************************************
  localparam int SCSC_ST_FAIL   = 0; // primary clock failed
  localparam int SCSC_ST_SWITCH = 1; // source changed
  localparam int SCSC_ST_REJECT = 2; // locked write ignored
  localparam int SCSC_ST_W      = 3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SCSC_CLK_HZ      = 50_000_000;
  localparam int SCSC_FAIL_US     = 1000; // no edge for this long means failure
  localparam int SCSC_FAIL_CYCLES = SCSC_FAIL_US * (SCSC_CLK_HZ / 1_000_000);

endpackage

// file: design/scsc_top.sv
/*
  System clock select control: picks RC (high or low), external pin clock
  or watchdog oscillator, detects a stalled primary source and falls back.
  Assumes oscillator clocks arrive as plain inputs sampled by clk_i and
  a classic Wishbone master on the register side.
*/
`timescale 1ns/100ps
`default_nettype none

module scsc_top
  import scsc_pkg::*;
#(
  parameter int FAIL_CYCLES = scsc_pkg::SCSC_FAIL_CYCLES
) (
  input  wire logic        clk_i,        // System clock, 50 MHz
  input  wire logic        rst_i,        // Synchronous reset, high
  input  wire logic        cyc_i,        // Wishbone cycle
  input  wire logic        stb_i,        // Wishbone strobe
  input  wire logic        we_i,         // Wishbone write enable
  input  wire logic [3:0]  adr_i,        // Wishbone byte address
  input  wire logic [3:0]  sel_i,        // Wishbone byte selects
  input  wire logic [31:0] dat_i,        // Wishbone write data
  output logic      [31:0] dat_o,        // Wishbone read data
  output logic             ack_o,        // Wishbone acknowledge
  input  wire logic        rc_hi_clk_i,  // RC oscillator, high setting
  input  wire logic        rc_lo_clk_i,  // RC oscillator, low setting
  input  wire logic        ext_clk_i,    // external_clock_input_pin
  input  wire logic        wdo_clk_i,    // watchdog_timer oscillator
  output logic             rc_en_o,      // Enable RC oscillator
  output logic             rc_low_o,     // RC frequency select, 1 = low
  output logic      [1:0]  clk_sel_o,    // Active source to the clock mux
  output logic             sys_clk_o,    // Selected clock, sampled
  output logic             irq_o         // Level interrupt
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic req, wr, rd;
  logic ack_q, ack_d;
  assign req = cyc_i & stb_i & ~ack_q;
  assign wr  = req & we_i & sel_i[0];
  assign rd  = req & ~we_i;

  // ****************************************
  // State
  // ****************************************
  logic [4:0]        ctl_q, ctl_d;
  // One-hot unlock tracker; any stray key write falls back to locked
  typedef enum logic [2:0] {
    SCSC_KEY_LOCKED = 3'b001,
    SCSC_KEY_HALF   = 3'b010,
    SCSC_KEY_OPEN   = 3'b100
  } scsc_key_t;
  scsc_key_t         key_q, key_d;
  logic [1:0]        act_q, act_d;
  logic              failed_q, failed_d;
  logic [SCSC_ST_W-1:0] st_q, st_d, msk_q, msk_d;
  logic              prev_q, prev_d;
  logic [31:0]       wd_q, wd_d;
  logic [31:0]       dat_q, dat_d;

  logic src_clk, edge_seen, fail_ev, rej_ev, sw_ev;

  always_comb begin
    case (act_q)
      SCSC_SRC_EXT: src_clk = ext_clk_i;
      SCSC_SRC_WDO: src_clk = wdo_clk_i;
      default:      src_clk = ctl_q[SCSC_CTL_RC_LOW] ? rc_lo_clk_i : rc_hi_clk_i;
    endcase
  end

  assign edge_seen = src_clk ^ prev_q;

  always_comb begin
    ctl_d    = ctl_q;
    key_d    = key_q;
    act_d    = act_q;
    failed_d = failed_q;
    prev_d   = src_clk;
    wd_d     = edge_seen ? 32'h0 : wd_q + 32'h1;
    rej_ev   = 1'b0;
    sw_ev    = 1'b0;
    fail_ev  = 1'b0;
    // Two-key unlock; any other unlock write relocks
    if (wr && adr_i == SCSC_OFF_UNLOCK) begin
      case (key_q)
        SCSC_KEY_LOCKED: key_d = (dat_i[7:0] == SCSC_KEY1) ? SCSC_KEY_HALF : SCSC_KEY_LOCKED;
        SCSC_KEY_HALF:   key_d = (dat_i[7:0] == SCSC_KEY2) ? SCSC_KEY_OPEN : SCSC_KEY_LOCKED;
        default:         key_d = SCSC_KEY_LOCKED;
      endcase
    end
    if (wr && adr_i == SCSC_OFF_CTRL) begin
      key_d = SCSC_KEY_LOCKED;
      if (key_q == SCSC_KEY_OPEN) begin
        ctl_d = dat_i[4:0];
        if (dat_i[1:0] != 2'h3) begin
          act_d    = dat_i[1:0];
          failed_d = 1'b0;
          wd_d     = 32'h0;
          sw_ev    = (dat_i[1:0] != act_q);
        end
      end else begin
        rej_ev = 1'b1;
      end
    end
    // Fallback to the RC high setting; the watchdog clock is only a
    // backup if the RC itself was the one that stalled.
    if (ctl_q[SCSC_CTL_FD_EN] && wd_q >= 32'(FAIL_CYCLES - 1) && !edge_seen) begin
      fail_ev  = 1'b1;
      failed_d = 1'b1;
      wd_d     = 32'h0;
      act_d    = (act_q == SCSC_SRC_RC) ? SCSC_SRC_WDO : SCSC_SRC_RC;
      ctl_d[SCSC_CTL_RC_EN]  = 1'b1;
      ctl_d[SCSC_CTL_RC_LOW] = 1'b0;
    end
  end

  // ****************************************
  // Interrupts and bus answer
  // ****************************************
  always_comb begin
    logic [SCSC_ST_W-1:0] clr, ev;
    clr = (wr && adr_i == SCSC_OFF_STATUS) ? dat_i[SCSC_ST_W-1:0] : '0;
    ev  = '0;
    ev[SCSC_ST_FAIL]   = fail_ev;
    ev[SCSC_ST_SWITCH] = sw_ev | fail_ev;
    ev[SCSC_ST_REJECT] = rej_ev;
    st_d  = (st_q & ~clr) | ev;          // Set wins over clear
    msk_d = (wr && adr_i == SCSC_OFF_MASK) ? dat_i[SCSC_ST_W-1:0] : msk_q;
    ack_d = req;
    dat_d = dat_q;
    if (rd) begin
      case (adr_i)
        SCSC_OFF_CTRL: begin
          dat_d = 32'h0;
          dat_d[4:0] = ctl_q;
          dat_d[SCSC_CTL_FAILED] = failed_q;
          dat_d[SCSC_CTL_LOCKED] = (key_q != SCSC_KEY_OPEN);
          dat_d[SCSC_CTL_ACT_LSB+1:SCSC_CTL_ACT_LSB] = act_q;
        end
        SCSC_OFF_STATUS: dat_d = {29'h0, st_q};
        SCSC_OFF_MASK:   dat_d = {29'h0, msk_q};
        default:         dat_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q    <= SCSC_CTL_RESET;
      key_q    <= SCSC_KEY_LOCKED;
      act_q    <= SCSC_SRC_RC;
      failed_q <= 1'b0;
      st_q     <= '0;
      msk_q    <= '0;
      prev_q   <= 1'b0;
      wd_q     <= 32'h0;
      ack_q    <= 1'b0;
      dat_q    <= 32'h0;
    end else begin
      ctl_q    <= ctl_d;
      key_q    <= key_d;
      act_q    <= act_d;
      failed_q <= failed_d;
      st_q     <= st_d;
      msk_q    <= msk_d;
      prev_q   <= prev_d;
      wd_q     <= wd_d;
      ack_q    <= ack_d;
      dat_q    <= dat_d;
    end
  end

  assign ack_o     = ack_q;
  assign dat_o     = dat_q;
  assign rc_en_o   = ctl_q[SCSC_CTL_RC_EN];
  assign rc_low_o  = ctl_q[SCSC_CTL_RC_LOW];
  assign clk_sel_o = act_q;
  assign sys_clk_o = prev_q;
  assign irq_o     = |(st_q & msk_q);

endmodule

`default_nettype wire

// file: tb/scsc_props.sv
/*
  Checker for scsc_top: bus answer, source and RC changes tied to causes.
  Sees only the top ports; bound to every scsc_top instance below.
*/
`timescale 1ns/100ps
`default_nettype none
module scsc_props (
  input wire logic       clk_i,    // Clock
  input wire logic       rst_i,    // Reset
  input wire logic       cyc_i,    // Cycle
  input wire logic       stb_i,    // Strobe
  input wire logic       ack_o,    // Acknowledge
  input wire logic       rc_en_o,  // RC enable
  input wire logic       rc_low_o, // RC low setting
  input wire logic [1:0] clk_sel_o // Active source
);
  // ********
  // Properties
  // ********
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
  // Outside a bus write only the fallback may move the source
  property p_sel; $changed(clk_sel_o) && !ack_o |-> clk_sel_o inside {2'h0, 2'h2}; endproperty
  a_sel: assert property (p_sel) else $error("source moved without cause");
  property p_no3; clk_sel_o != 2'h3; endproperty
  a_no3: assert property (p_no3) else $error("source code 3 active");
  property p_low; $changed(rc_low_o) && !ack_o |-> !rc_low_o; endproperty
  a_low: assert property (p_low) else $error("rc setting moved");
  property p_en; $fell(rc_en_o) |-> ack_o; endproperty
  a_en: assert property (p_en) else $error("rc disabled without write");
endmodule
bind scsc_top scsc_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .rc_en_o(rc_en_o), .rc_low_o(rc_low_o), .clk_sel_o(clk_sel_o));
`default_nettype wire

// file: tb/tb.sv
/*
  Bench for scsc_top: lock, source select, relock, fallback, interrupt.
  Assumes scsc_pkg and scsc_props are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import scsc_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, stop_q = 0;
  logic [3:0]  adr_i = 0, osc_q = 0, sel_q = 4'hF;
  logic        clk_seen;
  logic [31:0] dat_i = 0, dat_o, rd_q;
  logic        ack_o, rc_en_o, rc_low_o, sys_clk_o, irq_o, lo, en;
  logic [1:0]  clk_sel_o, s;
  int          n_errors = 0, check_count = 0, seed = 83;
  scsc_top #(.FAIL_CYCLES(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_q), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .rc_hi_clk_i(osc_q[0]), .rc_lo_clk_i(osc_q[1]), .ext_clk_i(osc_q[2]),
    .wdo_clk_i(osc_q[3]), .rc_en_o(rc_en_o), .rc_low_o(rc_low_o), .clk_sel_o(clk_sel_o),
    .sys_clk_o(sys_clk_o), .irq_o(irq_o));
  initial forever #10 clk_i = ~clk_i;
  // Stopping the pin clock models a dead external source
  always @(posedge clk_i) osc_q <= ~osc_q & {1'b1, ~stop_q, 2'h3};
  // ********
  // Tasks
  // ********
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    int i = 0;
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin @(posedge clk_i); i++; end while (ack_o !== 1'b1 && i < 20);
    if (i >= 20) begin n_errors++; close_out(); end
    rd_q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
    @(posedge clk_i);
  endtask
  function automatic logic [31:0] ctl(logic [1:0] s, logic lo, logic en, logic fd);
    return {27'h0, fd, lo, en, s};
  endfunction
  task automatic unlock();
    bus(1, SCSC_OFF_UNLOCK, {24'h0, SCSC_KEY1});
    bus(1, SCSC_OFF_UNLOCK, {24'h0, SCSC_KEY2});
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk("reset pins", 32'h10, {27'h0, rc_en_o, rc_low_o, clk_sel_o, irq_o});
    bus(0, SCSC_OFF_CTRL, 0);
    chk("ctrl reset", 32'h4, rd_q & 32'h31F);
    bus(1, SCSC_OFF_CTRL, ctl(SCSC_SRC_EXT, 0, 1, 0));
    chk("locked write", 32'h0, 32'(clk_sel_o));
    bus(0, SCSC_OFF_STATUS, 0);
    chk("reject flag", 32'h4, rd_q & 32'h7);
    bus(1, SCSC_OFF_MASK, 32'h4);
    chk("irq set", 32'h1, 32'(irq_o));
    bus(1, SCSC_OFF_STATUS, 32'h7);
    chk("irq clear", 32'h0, 32'(irq_o));
    sel_q <= 4'h0;
    bus(1, SCSC_OFF_MASK, 32'h0);
    sel_q <= 4'hF;
    bus(0, SCSC_OFF_MASK, 0);
    chk("byte lane", 32'h4, rd_q);
    $display("test lock done");
    for (int k = 0; k < 6; k++) begin
      s = 2'(k % 3);
      lo = 1'($random(seed));
      en = 1'($random(seed));
      unlock();
      bus(1, SCSC_OFF_CTRL, ctl(s, lo, en, 0));
      chk("source", 32'(s), 32'(clk_sel_o));
      chk("rc pins", {30'h0, en, lo}, {30'h0, rc_en_o, rc_low_o});
      bus(0, SCSC_OFF_CTRL, 0);
      chk("ctrl read", ctl(s, lo, en, 0) | {22'h0, s, 8'h0}, rd_q & 32'h31F);
      bus(1, SCSC_OFF_CTRL, ctl(2'(k % 2 + 1), ~lo, 1, 0));
      chk("relocked", 32'(s), 32'(clk_sel_o));
    end
    $display("test select done");
    unlock();
    bus(1, SCSC_OFF_CTRL, ctl(SCSC_SRC_EXT, 0, 1, 1));
    bus(1, SCSC_OFF_MASK, 32'h1);
    stop_q <= 1;
    for (int i = 0; i < 200 && clk_sel_o !== SCSC_SRC_RC; i++) @(posedge clk_i);
    if (clk_sel_o !== SCSC_SRC_RC) begin
      n_errors++;
      close_out();
    end
    @(posedge clk_i);
    chk("fallback", 32'h0, 32'(clk_sel_o));
    chk("fail irq", 32'h3, {30'h0, rc_en_o, irq_o});
    clk_seen = sys_clk_o;
    @(posedge clk_i);
    chk("sys clk", {31'h0, ~clk_seen}, {31'h0, sys_clk_o});
    $display("test fallback done");
    close_out();
  end
endmodule
`default_nettype wire
